//--- bench/bta_bus_model.sv
// Observed microcontroller bus model: one E cycle per call, data line released in E low
`timescale 1ns/100ps
module bta_bus_model (
    input  wire logic        core_clk,
    output logic      [15:0] mon_addr,
    output logic      [7:0]  mon_data,
    output logic             mon_rw,
    output logic             mon_e,
    output logic             instruction_start_n,
    output logic      [5:0]  mon_test_in,
    output logic             mon_count
);
    initial begin
        mon_addr            = 16'hc100;
        mon_data            = 8'h00;
        mon_rw              = 1'b1;
        mon_e               = 1'b0;
        instruction_start_n = 1'b1;
        mon_test_in         = 6'h00;
        mon_count           = 1'b0;
    end

    task cycle(input logic [15:0] a, input logic [7:0] d, input logic rw, input logic inst_n,
               input logic [5:0] t, input logic cnt);
        @(posedge core_clk);
        mon_addr            <= a;
        mon_data            <= d;
        mon_rw              <= rw;
        instruction_start_n <= inst_n;
        mon_test_in         <= t;
        mon_count           <= cnt;
        mon_e               <= 1'b1;
        repeat (4) @(posedge core_clk);
        mon_e <= 1'b0;
        repeat (3) @(posedge core_clk);
        // Released data line shows the inverse, so a stale byte cannot pass
        mon_data <= ~d;
        repeat (5) @(posedge core_clk);
    endtask : cycle
endmodule : bta_bus_model

//--- bench/bta_capture_test.sv
// Self-checking testbench for the bus trace capture unit
`timescale 1ns/100ps
module bta_capture_test;
    import bta_pkg::*;
    logic        core_clk;
    logic        rst;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    wire  logic  hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [15:0] mon_addr;
    logic [7:0]  mon_data;
    logic        mon_rw;
    logic        mon_e;
    logic        instruction_start_n;
    logic [5:0]  mon_test_in;
    logic        mon_count;
    logic        host_nonmaskable_irq;
    logic [31:0] rd;
    int          errors;
    int          n_checks;

    assign hready = hreadyout;

    bta_capture i_bta_capture (
        .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .mon_addr(mon_addr), .mon_data(mon_data),
        .mon_rw(mon_rw), .mon_e(mon_e), .instruction_start_n(instruction_start_n),
        .mon_test_in(mon_test_in), .mon_count(mon_count), .host_nonmaskable_irq(host_nonmaskable_irq)
    );

    bta_bus_model i_bta_bus_model (
        .core_clk(core_clk), .mon_addr(mon_addr), .mon_data(mon_data), .mon_rw(mon_rw),
        .mon_e(mon_e), .instruction_start_n(instruction_start_n), .mon_test_in(mon_test_in),
        .mon_count(mon_count)
    );

    always #5 core_clk = ~core_clk;

    task wrap_up;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Single word transfer; address held until accepted, data until hready
    task xfer(input logic wr, input logic [15:0] a, input logic [31:0] d);
        @(posedge core_clk);
        hsel   <= 1'b1;
        haddr  <= {16'h0000, a};
        htrans <= BTA_HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge core_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hready !== 1'b1);
        rd = hrdata;
        hsel <= 1'b0;
    endtask : xfer

    task lane(input logic [15:0] a, input logic [7:0] exp);
        xfer(1'b0, a, 32'h0);
        check({24'h0, rd[7:0]}, {24'h0, exp});
    endtask : lane

    // First nibble ends in the state stage
    task shift5(input logic [19:0] n);
        for (int i = 0; i < 5; i++)
            xfer(1'b1, BTA_SHIFT_ADDR, {28'h0, n[i*4+:4]});
    endtask : shift5

    task tbyte;
        xfer(1'b0, BTA_TRIG_LO, 32'h0);
    endtask : tbyte

    initial begin
        repeat (50000) @(posedge core_clk);
        errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        wrap_up();
    end

    initial begin
        core_clk = 1'b0;
        rst      = 1'b1;
        hsel     = 1'b0;
        haddr    = 32'h0;
        htrans   = 2'h0;
        hwrite   = 1'b0;
        hsize    = 3'h2;
        hwdata   = 32'h0;
        errors   = 0;
        n_checks = 0;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        check({31'h0, hresp}, 32'h0);
        xfer(1'b0, 16'h9000, 32'h0);
        check(rd, 32'h0);
        // Trigger map: clear the indexes in use, set one
        xfer(1'b1, 16'h4100, 32'h0);
        xfer(1'b1, 16'h4101, 32'h7f);
        xfer(1'b1, 16'h4102, 32'h0);
        xfer(1'b1, 16'h41f0, 32'h80);
        for (int i = 0; i < 5; i++) begin
            xfer(1'b1, BTA_SHIFT_ADDR, 32'(i + 1));
            tbyte();
            check({24'h0, rd[7:0]}, (i == 4) ? 32'h1 : 32'h0);
        end
        // Counter 2010 (aux select), state 0
        shift5(20'h20100);
        xfer(1'b1, BTA_CTRL_ADDR, 32'h1);
        i_bta_bus_model.cycle(16'hc100, 8'ha5, 1'b1, 1'b0, 6'h2a, 1'b1);
        i_bta_bus_model.cycle(16'hc101, 8'h5a, 1'b0, 1'b1, 6'h15, 1'b1);
        xfer(1'b1, BTA_CTRL_ADDR, 32'h0);
        // Host mode: this cycle must neither write nor step
        i_bta_bus_model.cycle(16'hc102, 8'h77, 1'b1, 1'b1, 6'h3f, 1'b1);
        xfer(1'b0, BTA_STEP_DN_ADDR, 32'h0);
        lane(BTA_LANE_AUX, 8'h15);
        lane(BTA_LANE_LOW, 8'h01);
        lane(BTA_LANE_DATA, 8'h5a);
        xfer(1'b0, BTA_STEP_DN_ADDR, 32'h0);
        lane(BTA_LANE_AUX, 8'hea);
        lane(BTA_LANE_HIGH, 8'hc1);
        lane(BTA_LANE_LOW, 8'h00);
        lane(BTA_LANE_DATA, 8'ha5);
        xfer(1'b0, BTA_STEP_UP_ADDR, 32'h0);
        lane(BTA_LANE_LOW, 8'h01);
        // Capture counting down: write at 2011, then step to 2010
        xfer(1'b1, BTA_CTRL_ADDR, 32'h5);
        i_bta_bus_model.cycle(16'hc102, 8'h77, 1'b1, 1'b1, 6'h3f, 1'b1);
        xfer(1'b1, BTA_CTRL_ADDR, 32'h0);
        lane(BTA_LANE_DATA, 8'ha5);
        xfer(1'b0, BTA_STEP_UP_ADDR, 32'h0);
        lane(BTA_LANE_DATA, 8'h77);
        // Trace-after: a set map entry moves state 0 to 1
        xfer(1'b1, BTA_CTRL_ADDR, 32'h1);
        i_bta_bus_model.cycle(16'hc1f0, 8'h11, 1'b1, 1'b1, 6'h00, 1'b1);
        xfer(1'b1, BTA_CTRL_ADDR, 32'h0);
        tbyte();
        check({28'h0, rd[3:0]}, 32'h1);
        check({31'h0, rd[7]}, 32'h1);
        // Nth execution with N of 2
        shift5(20'h00000);
        xfer(1'b1, BTA_PTCLR_ADDR, 32'h0);
        xfer(1'b1, BTA_PTLOAD_ADDR, 32'h1ffe);
        tbyte();
        check({30'h0, rd[6:5]}, 32'h1);
        xfer(1'b1, BTA_CTRL_ADDR, 32'h3);
        i_bta_bus_model.cycle(16'hc1f0, 8'h22, 1'b1, 1'b1, 6'h00, 1'b1);
        check({31'h0, host_nonmaskable_irq}, 32'h0);
        i_bta_bus_model.cycle(16'hc1f0, 8'h33, 1'b1, 1'b1, 6'h00, 1'b1);
        check({31'h0, host_nonmaskable_irq}, 32'h0);
        // Full is acted on by the next bus state, which ends the capture
        i_bta_bus_model.cycle(16'hc100, 8'h44, 1'b1, 1'b1, 6'h00, 1'b1);
        check({31'h0, host_nonmaskable_irq}, 32'h1);
        tbyte();
        check({31'h0, rd[6]}, 32'h1);
        xfer(1'b1, BTA_PTCLR_ADDR, 32'h0);
        tbyte();
        check({30'h0, rd[6:5]}, 32'h0);
        xfer(1'b1, BTA_CTRL_ADDR, 32'h0);
        // Interrupt clears on the edge that ends the transfer
        @(posedge core_clk);
        check({31'h0, host_nonmaskable_irq}, 32'h0);
        // Host step in state 0 clocks the post-trigger counter
        shift5(20'h00000);
        xfer(1'b1, BTA_PTLOAD_ADDR, 32'h0fff);
        tbyte();
        check({31'h0, rd[5]}, 32'h0);
        xfer(1'b0, BTA_STEP_UP_ADDR, 32'h0);
        tbyte();
        check({31'h0, rd[5]}, 32'h1);
        // Test select: the aux lane stores the live test byte (half flag set)
        shift5(20'h40000);
        xfer(1'b1, BTA_CTRL_ADDR, 32'h1);
        i_bta_bus_model.cycle(16'hc100, 8'h66, 1'b1, 1'b1, 6'h00, 1'b1);
        xfer(1'b1, BTA_CTRL_ADDR, 32'h0);
        xfer(1'b0, BTA_STEP_DN_ADDR, 32'h0);
        lane(BTA_LANE_AUX, 8'h20);
        lane(BTA_LANE_DATA, 8'h66);
        wrap_up();
    end
endmodule : bta_capture_test

//--- verilog/bta_capture.sv
// Bus trace capture unit: capture buffer, counter chain, trigger map, sequencer, post-trigger counter
// Contract
// - Capture buffer is 8K words of 32 bits in four byte lanes.
// - All lanes share one word address, the low 13 counter bits.
// - With aux selection the aux lane holds six test inputs, read/write and mark (inverted instruction start); with neither select, 00.
// - With test selection the aux lane stores state, post-trigger pulse, flags, match.
// - One capture-write strobe writes all lanes; one strobe records one bus state.
// - Four decoded read addresses each return one lane byte at the counter address.
// - Counter is 16 bits; low 13 address, bits 13 and 14 select aux/test.
// - Capture steps follow the direction control; host reads of B4B0/B4A0 step up/down regardless.
// - Host nibble load shifts data into top stage, each stage takes previous.
// - Sequencer advance pulse steps the counter chain once unless a host shift or step falls in the same cycle.
// - Host read of B4B0 increments, read of B4A0 decrements the chain once.
// - Counters ignore capture count pulses while host mode is asserted.
// - Any read in 4000-7FFF returns the live test byte.
// - Trigger map 16K x 1 indexed by A0-A13; writes there store D7.
// - Match asserts when bus address hits a set map entry; sequencer uses it.
// - State register counts up only, on advance enable; in host mode only the nibble shift loads it.
// - State register is the final chain stage and the low test-byte nibble.
// - Sequencer takes bus, state, mode, flags, match; makes irq, write, counter and state advance, pulses.
// - Post-trigger counter is 14 bits; half flag at 4096, full at 8192.
// - Trace-after: once triggered count every bus cycle; full stops capture.
// - Nth-execution: host preloads 8192-N, count per match, full ends capture.
// - Write B500 clears post-trigger counter; read B4B0 in state 00000 with state high select clear advances it.
// - Host write to B490 produces the nibble shift load.
`timescale 1ns/100ps
module bta_capture
    import bta_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [15:0] mon_addr,
    input  wire logic [7:0]  mon_data,
    input  wire logic        mon_rw,
    input  wire logic        mon_e,
    input  wire logic        instruction_start_n,
    input  wire logic [5:0]  mon_test_in,
    input  wire logic        mon_count,
    output logic             host_nonmaskable_irq
);

    function automatic logic in_trig_range(input logic [15:0] a);
        in_trig_range = (a >= BTA_TRIG_LO) && (a <= BTA_TRIG_HI);
    endfunction : in_trig_range

    // Pin synchronisers
    bta_mon_t    mon_s1_r;
    bta_mon_t    mon_s2_r;
    logic        e_s1_r;
    logic        e_s2_r;
    logic        e_s3_r;
    logic        bus_cycle;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mon_s1_r <= '0;
            mon_s2_r <= '0;
            e_s1_r   <= 1'b0;
            e_s2_r   <= 1'b0;
            e_s3_r   <= 1'b0;
        end else begin
            mon_s1_r <= '{addr: mon_addr, data: mon_data, rw: mon_rw,
                          instruction_start_n: instruction_start_n, test_in: mon_test_in, count: mon_count};
            mon_s2_r <= mon_s1_r;
            e_s1_r   <= mon_e;
            e_s2_r   <= e_s1_r;
            e_s3_r   <= e_s2_r;
        end
    end

    // Falling E is the rising edge of the inverted E clock: one bus state
    assign bus_cycle = e_s3_r & ~e_s2_r;

    // Storage and state
    // Four byte lanes, 8K words
    logic [31:0]         buf_mem [BTA_BUF_DEPTH];
    logic                trig_map [BTA_TRIG_DEPTH];
    logic [15:0]         cnt_r;
    logic [3:0]          state_r;
    logic [BTA_PT_W-1:0] pt_r;
    logic                trig_hit_r;
    logic                pt_pulse_r;
    logic [2:0]          ctrl_r;
    logic                host_mode;
    logic                pt_half;
    logic                pt_full;
    logic [7:0]          test_byte;
    logic [7:0]          aux_byte;
    logic [7:0]          lane0_byte;
    bta_seq_t            seq;

    assign host_mode = ~ctrl_r[BTA_CTL_MODE_N];
    assign pt_half   = pt_r >= BTA_PT_HALF;
    assign pt_full   = pt_r[BTA_PT_FULL_BIT];

    assign test_byte = {trig_hit_r, pt_full, pt_half, pt_pulse_r, state_r};
    assign aux_byte  = {~mon_s2_r.instruction_start_n, mon_s2_r.rw, mon_s2_r.test_in};

    // Upper counter bits pick the lane 0 source
    always_comb begin
        if (cnt_r[BTA_TEST_SEL_BIT]) begin
            lane0_byte = test_byte;
        end else if (cnt_r[BTA_AUX_SEL_BIT]) begin
            lane0_byte = aux_byte;
        end else begin
            lane0_byte = 8'h00;
        end
    end

    // AHB-Lite slave: one wait state on every NONSEQ transfer
    bta_ahb_st_t ahb_st_r;
    logic [15:0] a_r;
    logic        w_r;
    logic        hreadyout_r;
    logic        hresp_r;
    logic [31:0] hrdata_r;
    logic        op;
    logic        hw_shift;
    logic        hr_inc;
    logic        hr_dec;
    logic        hw_ptclr;
    logic        hr_test;
    logic        hw_trig;

    assign op       = ahb_st_r == BTA_AHB_DATA;
    assign hw_shift = op & w_r & (a_r == BTA_SHIFT_ADDR);
    assign hr_inc   = op & ~w_r & (a_r == BTA_STEP_UP_ADDR);
    assign hr_dec   = op & ~w_r & (a_r == BTA_STEP_DN_ADDR);
    assign hw_ptclr = op & w_r & (a_r == BTA_PTCLR_ADDR);
    assign hr_test  = op & ~w_r & in_trig_range(a_r);
    assign hw_trig  = op & w_r & in_trig_range(a_r);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ahb_st_r    <= BTA_AHB_IDLE;
            a_r         <= 16'h0000;
            w_r         <= 1'b0;
            hreadyout_r <= 1'b1;
            hresp_r     <= 1'b0;
        end else begin
            unique case (ahb_st_r)
                BTA_AHB_IDLE: begin
                    if (hsel && hready && htrans == BTA_HTRANS_NONSEQ) begin
                        a_r         <= haddr[15:0];
                        w_r         <= hwrite;
                        hreadyout_r <= 1'b0;
                        ahb_st_r    <= BTA_AHB_DATA;
                    end
                end
                BTA_AHB_DATA: begin
                    hreadyout_r <= 1'b1;
                    ahb_st_r    <= BTA_AHB_IDLE;
                end
            endcase
        end
    end

    // One decoded address per lane at the counter address
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hrdata_r <= 32'h0000_0000;
        end else if (op && !w_r) begin
            if (in_trig_range(a_r)) begin
                hrdata_r <= {24'h000000, test_byte};
            end else begin
                unique case (a_r)
                    BTA_LANE_AUX:    hrdata_r <= {24'h000000, buf_mem[cnt_r[BTA_BUF_AW-1:0]][31:24]};
                    BTA_LANE_HIGH:   hrdata_r <= {24'h000000, buf_mem[cnt_r[BTA_BUF_AW-1:0]][23:16]};
                    BTA_LANE_LOW:    hrdata_r <= {24'h000000, buf_mem[cnt_r[BTA_BUF_AW-1:0]][15:8]};
                    BTA_LANE_DATA:   hrdata_r <= {24'h000000, buf_mem[cnt_r[BTA_BUF_AW-1:0]][7:0]};
                    BTA_CTRL_ADDR:   hrdata_r <= {cnt_r, 9'h000, state_r, ctrl_r};
                    BTA_PTLOAD_ADDR: hrdata_r <= {18'h00000, pt_r};
                    default:         hrdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Control: host mode (active low bit), state high select, count direction
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= BTA_CTRL_RST;
        end else if (op && w_r && a_r == BTA_CTRL_ADDR) begin
            ctrl_r <= hwdata[2:0];
        end
    end

    // Lookup lags the address one core clock; E is far slower
    // Registered match from the map
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            trig_hit_r <= 1'b0;
        end else begin
            trig_hit_r <= trig_map[mon_s2_r.addr[BTA_TRIG_AW-1:0]];
        end
    end

    always_ff @(posedge core_clk) begin
        if (hw_trig) begin
            trig_map[a_r[BTA_TRIG_AW-1:0]] <= hwdata[BTA_TRIG_DBIT];
        end
    end

    // Sequencer array; state high select bit picks trace-after or Nth execution
    always_comb begin
        seq = '0;
        if (bus_cycle && !host_mode && mon_s2_r.count) begin
            if (!ctrl_r[BTA_CTL_SHS]) begin
                if (state_r == 4'h0) begin
                    seq.cap_wr  = 1'b1;
                    seq.cap_adv = 1'b1;
                    seq.st_adv  = trig_hit_r;
                end else if (state_r == 4'h1) begin
                    seq.cap_wr   = 1'b1;
                    seq.cap_adv  = 1'b1;
                    seq.pt_pulse = 1'b1;
                    seq.st_adv   = pt_full;
                    seq.irq_set  = pt_full;
                end
            end else if (state_r == 4'h0) begin
                // Count per match, full ends capture
                seq.cap_wr   = 1'b1;
                seq.cap_adv  = 1'b1;
                seq.pt_pulse = trig_hit_r;
                seq.st_adv   = pt_full;
                seq.irq_set  = pt_full;
            end
        end
    end

    // One strobe writes all four lanes
    always_ff @(posedge core_clk) begin
        if (seq.cap_wr) begin
            // Old address is written in the same edge that advances it
            buf_mem[cnt_r[BTA_BUF_AW-1:0]] <= {lane0_byte, mon_s2_r.addr, mon_s2_r.data};
        end
    end

    // Counter chain; host operations outrank a colliding capture step
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 16'h0000;
        end else if (hw_shift) begin
            // Data nibble enters the top stage
            cnt_r <= {hwdata[3:0], cnt_r[15:4]};
        end else if (hr_inc) begin
            cnt_r <= cnt_r + 16'h0001;
        end else if (hr_dec) begin
            cnt_r <= cnt_r - 16'h0001;
        end else if (seq.cap_adv && !host_mode) begin
            // One step in the chosen direction
            cnt_r <= ctrl_r[BTA_CTL_DOWN] ? cnt_r - 16'h0001 : cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r <= 4'h0;
        end else if (hw_shift) begin
            // Last stage takes the lowest counter nibble
            state_r <= cnt_r[3:0];
        end else if (seq.st_adv && !host_mode) begin
            state_r <= state_r + 4'h1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pt_r       <= '0;
            pt_pulse_r <= 1'b0;
        end else begin
            // Registered copy feeds the test byte only
            pt_pulse_r <= seq.pt_pulse;
            if (hw_ptclr) begin
                pt_r <= '0;
            end else if (op && w_r && a_r == BTA_PTLOAD_ADDR) begin
                pt_r <= hwdata[BTA_PT_W-1:0];
            end else if (hr_inc && state_r == 4'h0 && !ctrl_r[BTA_CTL_SHS]) begin
                pt_r <= pt_r + 14'h0001;
            end else if (seq.pt_pulse) begin
                pt_r <= pt_r + 14'h0001;
            end
        end
    end

    // Interrupt held until the host takes the analyzer back; set wins
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            host_nonmaskable_irq <= 1'b0;
        end else if (seq.irq_set) begin
            host_nonmaskable_irq <= 1'b1;
        end else if (host_mode) begin
            host_nonmaskable_irq <= 1'b0;
        end
    end

    assign hrdata    = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp     = hresp_r;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    AST_HRESP_OKAY: assert property (hresp == 1'b0)
        else $error("slave answered other than OKAY");
    AST_ONE_WAIT: assert property (ahb_st_r == BTA_AHB_IDLE && hsel && hready && htrans == BTA_HTRANS_NONSEQ
        |=> !hreadyout ##1 hreadyout)
        else $error("transfer did not take exactly one wait state");
    AST_SHIFT: assert property (hw_shift |=> cnt_r == {$past(hwdata[3:0]), $past(cnt_r[15:4])}
        && state_r == $past(cnt_r[3:0]))
        else $error("nibble shift wrong");
    AST_STEP_UP: assert property (hr_inc |=> cnt_r == $past(cnt_r) + 16'h0001)
        else $error("host step up wrong");
    AST_STEP_DOWN: assert property (hr_dec |=> cnt_r == $past(cnt_r) - 16'h0001)
        else $error("host step down wrong");
    AST_HOLD: assert property (host_mode && !op ##1 !op |-> $stable(cnt_r) && $stable(state_r))
        else $error("counters moved in host mode");
    AST_STATE_UP: assert property (!hw_shift ##1 state_r != $past(state_r)
        |-> state_r == $past(state_r) + 4'h1)
        else $error("state moved other than up by one");
    AST_PT_CLEAR: assert property (hw_ptclr |=> pt_r == '0)
        else $error("post-trigger counter not cleared");
    AST_CAP_WRITE: assert property (seq.cap_wr ##1 !seq.cap_wr
        |-> buf_mem[$past(cnt_r[12:0])][15:0] == $past({mon_s2_r.addr[7:0], mon_s2_r.data}))
        else $error("capture not stored at pre-advance address");
    AST_TEST_READ: assert property (hr_test |=> hrdata[7:0] == $past(test_byte) ##1 hreadyout)
        else $error("test byte read wrong");
    AST_FULL_STOP: assert property (seq.irq_set |=> state_r != $past(state_r) ##1 host_nonmaskable_irq)
        else $error("full flag did not end capture");

    // Capture path and host access checks
    AST_CNT_ADV: assert property (seq.cap_adv && !hw_shift && !hr_inc && !hr_dec
        |=> cnt_r == ($past(ctrl_r[BTA_CTL_DOWN]) ? $past(cnt_r) - 16'h0001 : $past(cnt_r) + 16'h0001))
        else $error("capture step not one in the chosen direction");
    AST_NO_HOST_CAPTURE: assert property (host_mode |-> !seq.cap_wr && !seq.cap_adv && !seq.st_adv)
        else $error("capture strobe while host mode asserted");
    AST_IRQ_HOLD: assert property (host_nonmaskable_irq && !host_mode |=> host_nonmaskable_irq)
        else $error("interrupt dropped before host took over");
    AST_TRIG_STORE: assert property (hw_trig
        |=> trig_map[$past(a_r[BTA_TRIG_AW-1:0])] == $past(hwdata[BTA_TRIG_DBIT]))
        else $error("trigger map entry not stored");
    AST_LANE_READ: assert property (op && !w_r && a_r == BTA_LANE_DATA
        |=> hrdata[7:0] == $past(buf_mem[cnt_r[BTA_BUF_AW-1:0]][7:0]))
        else $error("data lane read wrong");
    AST_AUX_CAPTURE: assert property (seq.cap_wr && !cnt_r[BTA_TEST_SEL_BIT] && cnt_r[BTA_AUX_SEL_BIT]
        |=> buf_mem[$past(cnt_r[BTA_BUF_AW-1:0])][31:24]
        == $past({~mon_s2_r.instruction_start_n, mon_s2_r.rw, mon_s2_r.test_in}))
        else $error("aux lane not stored");

endmodule : bta_capture

//--- verilog/bta_pkg.sv
// Package: address map, field layout, reset values and carriers for the bus trace capture unit
package bta_pkg;

    // Host address map (byte address, low 16 bits of haddr)
    localparam logic [15:0] BTA_TRIG_LO      = 16'h4000;
    localparam logic [15:0] BTA_TRIG_HI      = 16'h7fff;
    localparam logic [15:0] BTA_CTRL_ADDR    = 16'hb440;
    localparam logic [15:0] BTA_PTLOAD_ADDR  = 16'hb450;
    localparam logic [15:0] BTA_SHIFT_ADDR   = 16'hb490;
    localparam logic [15:0] BTA_STEP_DN_ADDR = 16'hb4a0;
    localparam logic [15:0] BTA_STEP_UP_ADDR = 16'hb4b0;
    localparam logic [15:0] BTA_LANE_AUX     = 16'hb4c0;
    localparam logic [15:0] BTA_LANE_HIGH    = 16'hb4d0;
    localparam logic [15:0] BTA_LANE_LOW     = 16'hb4e0;
    localparam logic [15:0] BTA_LANE_DATA    = 16'hb4f0;
    localparam logic [15:0] BTA_PTCLR_ADDR   = 16'hb500;

    // Sizes
    localparam int BTA_BUF_AW   = 13;
    localparam int BTA_BUF_DEPTH = 8192;
    localparam int BTA_TRIG_AW  = 14;
    localparam int BTA_TRIG_DEPTH = 16384;
    localparam int BTA_PT_W     = 14;

    // Field positions
    localparam int BTA_AUX_SEL_BIT  = 13;
    localparam int BTA_TEST_SEL_BIT = 14;
    localparam int BTA_PT_FULL_BIT  = 13;
    localparam int BTA_CTL_MODE_N   = 0;
    localparam int BTA_CTL_SHS      = 1;
    localparam int BTA_CTL_DOWN     = 2;
    localparam int BTA_TRIG_DBIT    = 7;

    // Thresholds, reset values and the NONSEQ transfer code
    localparam logic [13:0] BTA_PT_HALF  = 14'h1000;
    localparam logic [2:0]  BTA_CTRL_RST = 3'h0;
    localparam logic [1:0]  BTA_HTRANS_NONSEQ = 2'h2;

    typedef enum logic {BTA_AHB_IDLE, BTA_AHB_DATA} bta_ahb_st_t;

    // One sampled state of the observed microcontroller bus
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  data;
        logic        rw;
        logic        instruction_start_n;
        logic [5:0]  test_in;
        logic        count;
    } bta_mon_t;

    // Control outputs of the sequencing logic for one bus cycle
    typedef struct packed {
        logic cap_wr;
        logic cap_adv;
        logic st_adv;
        logic pt_pulse;
        logic irq_set;
    } bta_seq_t;

endpackage : bta_pkg
